// [verilog/dcc_pkg.sv]
// dcc_pkg: constants shared by the dual comparator control block.
// assumes a single clock domain at the core instruction-phase rate.
package dcc_pkg;

  // digitised analog level carried on each comparator pin
  localparam int LEVEL_W = 8;
  localparam int PIN_COUNT = 4;
  localparam int REG_W = 8;
  localparam int MODE_W = 3;

  // comparator_control_reg field positions and reset value
  localparam int CTRL_SECOND_OUT_BIT = 7;
  localparam int CTRL_FIRST_OUT_BIT = 6;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [2:0] CTRL_MODE_RESET = 3'h0;

  // peripheral_flag_reg field position and reset value
  localparam int FLAG_CHANGE_BIT = 6;
  localparam logic FLAG_RESET = 1'b0;

  // comparator_mode_field encodings
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] MODE_INDEPENDENT = 3'h1;
  localparam logic [2:0] MODE_INTERNAL_REF = 3'h2;
  localparam logic [2:0] MODE_SHARED_PLUS = 3'h3;
  localparam logic [2:0] MODE_OFF = 3'h7;

  // pin indices used by the input routing
  localparam int PIN_FIRST_MINUS = 0;
  localparam int PIN_SECOND_MINUS = 1;
  localparam int PIN_SECOND_PLUS = 2;
  localparam int PIN_FIRST_PLUS = 3;

  // all pins configured as analog inputs
  localparam logic [3:0] PINS_ALL_ANALOG = 4'hF;
  localparam logic [3:0] PINS_NONE_ANALOG = 4'h0;
  // independent modes use all four pins, shared modes only three
  localparam logic [3:0] PINS_SHARED_ANALOG = 4'h7;
  localparam logic [3:0] PINS_IREF_ANALOG = 4'h3;

endpackage : dcc_pkg

// [verilog/dcc_comparator_cell.sv]
// dcc_comparator_cell: one comparator seen from the digital side.
// assumes the two levels are digitised and synchronous to clk_in.
`timescale 1ns/1ps
module dcc_comparator_cell (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  input wire logic [dcc_pkg::LEVEL_W-1:0] noninverting_input_in,
  input wire logic [dcc_pkg::LEVEL_W-1:0] inverting_input_in,
  output logic result_out
);
  import dcc_pkg::*;

  logic result_q;
  logic result_d;

  // equal levels hold the last decision, standing in for the offset band
  always_comb begin
    result_d = result_q;
    if (!enable_in) begin
      result_d = 1'b0;
    end else if (noninverting_input_in > inverting_input_in) begin
      result_d = 1'b1;
    end else if (noninverting_input_in < inverting_input_in) begin
      result_d = 1'b0;
    end
  end

  // powered down during reset, output reads low
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      result_q <= 1'b0;
    end else begin
      result_q <= result_d;
    end
  end

  assign result_out = result_q;

endmodule : dcc_comparator_cell

// [verilog/dcc_change_detect.sv]
// dcc_change_detect: mismatch latch and the comparator change flag.
// assumes access and write strobes are one-cycle pulses on clk_in.
`timescale 1ns/1ps
module dcc_change_detect (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [1:0] outputs_in,
  input wire logic ctrl_access_in,
  input wire logic flag_wr_in,
  input wire logic flag_wr_data_in,
  output logic flag_out,
  output logic mismatch_out
);
  import dcc_pkg::*;

  logic [1:0] copy_q;
  logic [1:0] copy_d;
  logic flag_q;
  logic flag_d;
  logic mismatch;

  // compare live outputs with the copy taken at the last access
  assign mismatch = (outputs_in != copy_q);

  // an access refreshes the copy; a change seen in that same cycle
  // still sets the flag through the mismatch before the copy takes it
  always_comb begin
    copy_d = copy_q;
    if (ctrl_access_in) begin
      copy_d = outputs_in;
    end
  end

  // set wins over a software clear, and keeps winning while mismatched
  always_comb begin
    flag_d = flag_q;
    if (flag_wr_in) begin
      flag_d = flag_wr_data_in;
    end
    if (mismatch) begin
      flag_d = 1'b1;
    end
  end

  // flag and copy registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      copy_q <= 2'h0;
      flag_q <= FLAG_RESET;
    end else begin
      copy_q <= copy_d;
      flag_q <= flag_d;
    end
  end

  assign flag_out = flag_q;
  assign mismatch_out = mismatch;

endmodule : dcc_change_detect

// [verilog/dcc_top.sv]
// dcc_top: control and status side of a two-comparator module.
// assumes pin levels arrive digitised and synchronous to clk_in, and
// register strobes are one-cycle pulses from the core.
`timescale 1ns/1ps
module dcc_top (
  input wire logic clk_in,
  input wire logic reset_n_in,
  // digitised levels on the four comparator pins
  input wire logic [dcc_pkg::LEVEL_W-1:0] pin0_level_in,
  input wire logic [dcc_pkg::LEVEL_W-1:0] pin1_level_in,
  input wire logic [dcc_pkg::LEVEL_W-1:0] pin2_level_in,
  input wire logic [dcc_pkg::LEVEL_W-1:0] pin3_level_in,
  input wire logic [dcc_pkg::LEVEL_W-1:0] internal_ref_level_in,
  // comparator_control_reg access
  input wire logic ctrl_wr_in,
  input wire logic [dcc_pkg::REG_W-1:0] ctrl_wr_data_in,
  input wire logic ctrl_rd_in,
  output logic [dcc_pkg::REG_W-1:0] ctrl_rd_data_out,
  // peripheral_flag_reg access
  input wire logic flag_wr_in,
  input wire logic [dcc_pkg::REG_W-1:0] flag_wr_data_in,
  output logic [dcc_pkg::REG_W-1:0] flag_rd_data_out,
  // enables held elsewhere in the core
  input wire logic comparator_irq_enable_in,
  input wire logic peripheral_irq_enable_in,
  input wire logic global_irq_enable_in,
  input wire logic sleep_in,
  // status
  output logic first_comparator_output_out,
  output logic second_comparator_output_out,
  output logic comparator_change_flag_out,
  output logic [dcc_pkg::PIN_COUNT-1:0] pin_analog_out,
  output logic comparators_on_out,
  output logic irq_out,
  output logic wake_out
);
  import dcc_pkg::*;

  logic [MODE_W-1:0] mode_q;
  logic [MODE_W-1:0] mode_d;
  logic [PIN_COUNT-1:0] pin_analog_q;
  logic [PIN_COUNT-1:0] pin_analog_d;
  logic cmp_enable;
  logic [LEVEL_W-1:0] first_plus;
  logic [LEVEL_W-1:0] first_minus;
  logic [LEVEL_W-1:0] second_plus;
  logic [LEVEL_W-1:0] second_minus;
  logic first_out;
  logic second_out;
  logic change_flag;
  logic ctrl_access;
  logic [LEVEL_W-1:0] pins [PIN_COUNT];

  // pin array so the routing function can index it
  assign pins[0] = pin0_level_in;
  assign pins[1] = pin1_level_in;
  assign pins[2] = pin2_level_in;
  assign pins[3] = pin3_level_in;

  // modes 000 and 111 keep both comparators powered down
  function automatic logic mode_is_on(input logic [MODE_W-1:0] mode);
    logic on;
    on = 1'b1;
    if (mode == MODE_RESET) begin
      on = 1'b0;
    end else if (mode == MODE_OFF) begin
      on = 1'b0;
    end
    return on;
  endfunction : mode_is_on

  // pins that stay analog inputs in a given mode
  function automatic logic [PIN_COUNT-1:0] mode_pins(
    input logic [MODE_W-1:0] mode
  );
    logic [PIN_COUNT-1:0] p;
    case (mode)
      MODE_RESET: begin
        p = PINS_ALL_ANALOG;
      end
      MODE_OFF: begin
        p = PINS_NONE_ANALOG;
      end
      MODE_INTERNAL_REF: begin
        p = PINS_IREF_ANALOG;
      end
      MODE_SHARED_PLUS: begin
        p = PINS_SHARED_ANALOG;
      end
      default: begin
        p = PINS_ALL_ANALOG;
      end
    endcase
    return p;
  endfunction : mode_pins

  // mode register: only software writes or reset change it, so sleep
  // and wake-up leave it as it was
  always_comb begin
    mode_d = mode_q;
    if (ctrl_wr_in) begin
      mode_d = ctrl_wr_data_in[CTRL_MODE_LSB +: MODE_W];
    end
  end

  // pin configuration follows the mode that is about to take effect
  always_comb begin
    pin_analog_d = mode_pins(mode_d);
  end

  // control state; reset selects the comparator reset mode
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q <= CTRL_MODE_RESET;
      pin_analog_q <= PINS_ALL_ANALOG;
    end else begin
      mode_q <= mode_d;
      pin_analog_q <= pin_analog_d;
    end
  end

  assign cmp_enable = mode_is_on(mode_q);

  // input routing; sleep_in does not enter here on purpose, the
  // comparators keep deciding while the core sleeps
  always_comb begin
    first_minus = pins[PIN_FIRST_MINUS];
    second_minus = pins[PIN_SECOND_MINUS];
    first_plus = pins[PIN_FIRST_PLUS];
    second_plus = pins[PIN_SECOND_PLUS];
    case (mode_q)
      MODE_INTERNAL_REF: begin
        first_plus = internal_ref_level_in;
        second_plus = internal_ref_level_in;
      end
      MODE_SHARED_PLUS: begin
        first_plus = pins[PIN_SECOND_PLUS];
        second_plus = pins[PIN_SECOND_PLUS];
      end
      default: begin
        first_plus = pins[PIN_FIRST_PLUS];
        second_plus = pins[PIN_SECOND_PLUS];
      end
    endcase
  end

  // first comparator
  dcc_comparator_cell u_first_cmp (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .enable_in(cmp_enable),
    .noninverting_input_in(first_plus),
    .inverting_input_in(first_minus),
    .result_out(first_out)
  );

  // second comparator
  dcc_comparator_cell u_second_cmp (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .enable_in(cmp_enable),
    .noninverting_input_in(second_plus),
    .inverting_input_in(second_minus),
    .result_out(second_out)
  );

  // a read or a write both count as an access that ends the mismatch
  assign ctrl_access = ctrl_rd_in | ctrl_wr_in;

  // change detection and the sticky flag
  dcc_change_detect u_change (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .outputs_in({second_out, first_out}),
    .ctrl_access_in(ctrl_access),
    .flag_wr_in(flag_wr_in),
    .flag_wr_data_in(flag_wr_data_in[FLAG_CHANGE_BIT]),
    .flag_out(change_flag),
    .mismatch_out()
  );

  // read views; unused bits read as zero
  always_comb begin
    ctrl_rd_data_out = '0;
    ctrl_rd_data_out[CTRL_SECOND_OUT_BIT] = second_out;
    ctrl_rd_data_out[CTRL_FIRST_OUT_BIT] = first_out;
    ctrl_rd_data_out[CTRL_MODE_LSB +: MODE_W] = mode_q;
    flag_rd_data_out = '0;
    flag_rd_data_out[FLAG_CHANGE_BIT] = change_flag;
  end

  // request needs all three enables; wake only needs the local one so
  // a sleeping core with interrupts masked globally still resumes
  assign irq_out = change_flag & comparator_irq_enable_in &
                   peripheral_irq_enable_in & global_irq_enable_in;
  assign wake_out = sleep_in & change_flag &
                    comparator_irq_enable_in;

  assign first_comparator_output_out = first_out;
  assign second_comparator_output_out = second_out;
  assign comparator_change_flag_out = change_flag;
  assign pin_analog_out = pin_analog_q;
  assign comparators_on_out = cmp_enable;

endmodule : dcc_top

// [bench/dcc_props.sv]
// dcc_props: port-level checks on dcc_top, bound in from the bench top.
// assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module dcc_props (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] pin0_level_in,
  input wire logic [7:0] pin1_level_in,
  input wire logic [7:0] pin3_level_in,
  input wire logic [7:0] internal_ref_level_in,
  input wire logic ctrl_wr_in,
  input wire logic ctrl_rd_in,
  input wire logic [7:0] ctrl_rd_data_out,
  input wire logic flag_wr_in,
  input wire logic [7:0] flag_wr_data_in,
  input wire logic [7:0] flag_rd_data_out,
  input wire logic comparator_irq_enable_in,
  input wire logic peripheral_irq_enable_in,
  input wire logic global_irq_enable_in,
  input wire logic sleep_in,
  input wire logic first_comparator_output_out,
  input wire logic second_comparator_output_out,
  input wire logic comparator_change_flag_out,
  input wire logic [3:0] pin_analog_out,
  input wire logic comparators_on_out,
  input wire logic irq_out,
  input wire logic wake_out
);
  // short views of the outputs and of any control register access
  wire logic [1:0] o = {second_comparator_output_out,
    first_comparator_output_out};
  wire logic acc = ctrl_rd_in | ctrl_wr_in;
  wire logic f = comparator_change_flag_out;
  wire logic [2:0] md = ctrl_rd_data_out[2:0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // a read, then a quiet cycle: the copy then matches the outputs
  sequence rd_quiet;
    ctrl_rd_in ##1 (!acc && $stable(o));
  endsequence
  // an output edge with no access nearby, so the copy cannot hide it
  sequence chg_alone;
    $changed(o) && !acc && !$past(acc) && !flag_wr_in;
  endsequence
  irq_gate_a:
    assert property (irq_out == (f & comparator_irq_enable_in &
      peripheral_irq_enable_in & global_irq_enable_in))
      else $error("irq gating wrong");
  wake_gate_a:
    assert property (wake_out == (sleep_in & f & comparator_irq_enable_in))
      else $error("wake gating wrong");
  read_layout_a:
    assert property (ctrl_rd_data_out[7:3] == {o, 3'h0} &&
      flag_rd_data_out == {1'b0, f, 6'h00}) else $error("read layout wrong");
  change_sets_a:
    assert property (chg_alone |=> f) else $error("change missed");
  clear_after_read_a:
    assert property (rd_quiet ##0 (flag_wr_in && !flag_wr_data_in[6])
      |=> !f) else $error("flag did not clear");
  mismatch_holds_a:
    assert property (rd_quiet ##1 $changed(o) |=> f)
      else $error("mismatch lost");
  off_modes_a:
    assert property ((md == 3'h0 || md == 3'h7) |-> !comparators_on_out
      ##1 o == 2'h0) else $error("comparator not off");
  reset_state_a:
    assert property ($rose(reset_n_in) |-> ctrl_rd_data_out == 8'h00 &&
      pin_analog_out == 4'hF) else $error("reset state wrong");
  first_compare_a:
    assert property (md == 3'h1 && pin3_level_in != pin0_level_in |=>
      o[0] == $past(pin3_level_in > pin0_level_in))
      else $error("first comparator wrong");
  iref_route_a:
    assert property (md == 3'h2 && internal_ref_level_in != pin1_level_in
      |=> o[1] == $past(internal_ref_level_in > pin1_level_in))
      else $error("reference routing wrong");
endmodule : dcc_props

// [bench/dcc_analog_src.sv]
// dcc_analog_src: digitised sources on four pins and the internal ref.
// assumes step_in is set just after an edge; levels move 1 ns after.
`timescale 1ns/1ps
module dcc_analog_src (
  input wire logic clk_in,
  input wire logic step_in,
  output logic [4:0][7:0] lvl_out
);
  initial lvl_out = '0;
  // a narrow range makes equal levels common, so the hold case is hit
  always @(posedge clk_in)
    if (step_in)
      for (int k = 0; k < 5; k++) lvl_out[k] <= #1 8'($urandom % 4);
endmodule : dcc_analog_src

// [bench/dual_comparator_control_tb_top.sv]
// dual_comparator_control_tb_top: random bench with a reference model.
// assumes dcc_props and dcc_analog_src are compiled before this file.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module dual_comparator_control_tb_top;
  logic clk_in = 1'b0;
  logic rst_n, cwr, crd, fwr, step, cie, pie, global_irq_enable, slp;
  logic c1, c2, flg, con, irq, wk;
  logic [7:0] cwd, fwd, crdd, frdd;
  logic [4:0][7:0] lv;
  logic [3:0] pa;
  logic [31:0] r;
  logic [25:0] ev;
  int m, o, cp, f, on, a, b, err_count = 0, n_tests = 0;
  wire logic [25:0] dv = {c2, c1, crdd, pa, con, flg, frdd, irq, wk};
  always #5 clk_in = ~clk_in;
  dcc_top dut (.clk_in(clk_in), .reset_n_in(rst_n), .pin0_level_in(lv[0]),
    .pin1_level_in(lv[1]), .pin2_level_in(lv[2]), .pin3_level_in(lv[3]),
    .internal_ref_level_in(lv[4]), .ctrl_wr_in(cwr), .ctrl_wr_data_in(cwd),
    .ctrl_rd_in(crd), .ctrl_rd_data_out(crdd), .flag_wr_in(fwr),
    .flag_wr_data_in(fwd), .flag_rd_data_out(frdd),
    .comparator_irq_enable_in(cie), .peripheral_irq_enable_in(pie),
    .global_irq_enable_in(global_irq_enable), .sleep_in(slp),
    .first_comparator_output_out(c1), .second_comparator_output_out(c2),
    .comparator_change_flag_out(flg), .pin_analog_out(pa),
    .comparators_on_out(con), .irq_out(irq), .wake_out(wk));
  dcc_analog_src src (.clk_in(clk_in), .step_in(step), .lvl_out(lv));
  // reference model: flag from old outputs, routing from the old mode
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      m = 0; o = 0; cp = 0; f = 0;
    end else begin
      f = o != cp ? 1 : fwr ? fwd[6] : f;
      if (crd | cwr) cp = o;
      on = m != 0 && m != 7;
      a = m == 2 ? lv[4] : m == 3 ? lv[2] : lv[3];
      b = m == 2 ? lv[4] : lv[2];
      o[0] = !on ? 0 : a > lv[0] ? 1 : a < lv[0] ? 0 : o[0];
      o[1] = !on ? 0 : b > lv[1] ? 1 : b < lv[1] ? 0 : o[1];
      if (cwr) m = cwd[2:0];
    end
  end
  // every cycle, the settled ports against the model
  always @(negedge clk_in) begin
    ev = {o[1:0], o[1:0], 3'h0, m[2:0], m == 0 ? 4'hF : m == 7 ? 4'h0 :
      m == 2 ? 4'h3 : m == 3 ? 4'h7 : 4'hF, m != 0 && m != 7, f[0], 1'b0,
      f[0], 6'h00, f[0] & cie & pie & global_irq_enable, slp & f[0] & cie};
    `CHK(dv[25:11], ev[25:11])
    `CHK(dv[10:0], ev[10:0])
  end
  // one random cycle; no access just after a step or a mode write,
  // since an output edge on an access edge may legally be missed
  task automatic drive();
    logic hz;
    hz = step | cwr;
    r = $urandom;
    step = r[2:0] == 3'h0;
    crd = !hz && r[4:3] == 2'h0;
    cwr = !hz && !crd && r[7:5] == 3'h0;
    fwr = r[9:8] == 2'h0;
    {cie, pie, global_irq_enable, slp} = r[13:10] | r[17:14];
    cwd = r[25:18];
    fwd = r[31:24];
  endtask : drive
  task automatic conclude();
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    void'($urandom(4363));
    {rst_n, cwr, crd, fwr, step, cie, pie, global_irq_enable, slp} = '0;
    cwd = 8'h00;
    fwd = 8'h00;
    repeat (8) @(posedge clk_in);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 6000; i++) begin
      @(posedge clk_in);
      #1 drive();
      if (i == 3000) rst_n = 1'b0;
      if (i == 3004) rst_n = 1'b1;
    end
    conclude();
  end
  // the loop needs about 6000 cycles; twice that means a hang
  initial begin
    #120000;
    err_count++;
    conclude();
  end
endmodule : dual_comparator_control_tb_top
bind dcc_top dcc_props u_props (.*);
